// *** hw/ipc_pkg.sv ***
// Shared constants and carrier types for the infrared pulse codec
`default_nettype none

package ipc_pkg;

    // =====================================================================
    // Counter geometry
    // =====================================================================
    localparam int unsigned IPC_CNT_W = 4;

    // Receive decoder: a count above this may be restarted by a new pulse
    localparam logic [IPC_CNT_W-1:0] IPC_DEC_HOLD_LAST = 4'h7;
    // Receive decoder: count value at which the decoded bit ends
    localparam logic [IPC_CNT_W-1:0] IPC_DEC_END      = 4'hF;
    // Transmit encoder: last x16 tick of one bit time
    localparam logic [IPC_CNT_W-1:0] IPC_BIT_LAST     = 4'hF;

    // =====================================================================
    // Pulse width selection
    // =====================================================================
    typedef enum logic [1:0] {
        IPC_WIDTH_3_16 = 2'h0,
        IPC_WIDTH_1_16 = 2'h1,
        IPC_WIDTH_1_32 = 2'h2
    } ipc_width_t;

    // Last tick index of the narrow pulse, counted in the selected base clock
    localparam logic [IPC_CNT_W-1:0] IPC_W3_16_LAST = 4'h2;
    localparam logic [IPC_CNT_W-1:0] IPC_W1_16_LAST = 4'h0;
    localparam logic [IPC_CNT_W-1:0] IPC_W1_32_LAST = 4'h0;

    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic IPC_LINE_IDLE = 1'b1;

    // =====================================================================
    // Carriers
    // =====================================================================
    typedef struct packed {
        logic       enable;
        ipc_width_t width_sel;
    } ipc_cfg_t;

    typedef struct packed {
        logic x16;
        logic x32;
    } ipc_ref_tick_t;

endpackage

`default_nettype wire

// *** hw/ipc_tick_counter.sv ***
// Small tick counter shared by the encoder and decoder timing paths
`timescale 1ns/1ns
`default_nettype none

module ipc_tick_counter
    import ipc_pkg::*;
#(
    parameter int unsigned W = IPC_CNT_W
) (
    input  wire logic         clock,
    input  wire logic         resetn,
    input  wire logic         clear,
    input  wire logic         tick,
    input  wire logic         hold,
    output logic [W-1:0]      count
);

    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;

    // Clear wins over a tick in the same cycle
    always_comb begin
        count_nxt = count_r;
        if (clear) begin
            count_nxt = '0;
        end else if (tick && !hold) begin
            count_nxt = count_r + W'(1);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count = count_r;

endmodule

`default_nettype wire

// *** hw/ipc_codec.sv ***
// Infrared pulse encoder and decoder between the serial core and the pins
`timescale 1ns/1ns
`default_nettype none

module ipc_codec
    import ipc_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          resetn,
    input  wire ipc_cfg_t      cfg,
    input  wire logic          baud_x16_ref_clock,
    input  wire logic          baud_x32_ref_clock,
    input  wire logic          serial_tx_in,
    output logic               tx_pin,
    input  wire logic          rx_pin,
    output logic               decoded_serial_in
);

    // =====================================================================
    // Reference ticks
    // =====================================================================
    // Both references are one-cycle enables from the core's baud divider
    ipc_ref_tick_t ref_tick;

    always_comb begin
        ref_tick.x16 = baud_x16_ref_clock;
        ref_tick.x32 = baud_x32_ref_clock;
    end

    // =====================================================================
    // Transmit encoder
    // =====================================================================
    logic                 enc_in_zero_r;
    logic                 enc_in_zero_nxt;
    logic                 enc_pulse_r;
    logic                 enc_pulse_nxt;
    logic                 enc_start;
    logic                 enc_sel_tick;
    logic [IPC_CNT_W-1:0] enc_width_last;
    logic [IPC_CNT_W-1:0] enc_bit_cnt;
    logic [IPC_CNT_W-1:0] enc_wid_cnt;
    logic                 tx_pin_r;
    logic                 tx_pin_nxt;

    // Width selection is sampled live; config must not change mid-character
    always_comb begin
        case (cfg.width_sel)
            IPC_WIDTH_1_16: begin
                enc_sel_tick   = ref_tick.x16;
                enc_width_last = IPC_W1_16_LAST;
            end
            IPC_WIDTH_1_32: begin
                enc_sel_tick   = ref_tick.x32;
                enc_width_last = IPC_W1_32_LAST;
            end
            default: begin
                enc_sel_tick   = ref_tick.x16;
                enc_width_last = IPC_W3_16_LAST;
            end
        endcase
    end

    // A pulse starts on entry to a zero bit, and again each full bit time
    // that the line stays low, so the pulse spacing is exactly one bit.
    always_comb begin
        enc_in_zero_nxt = !serial_tx_in;
        enc_start       = !serial_tx_in
                          && (!enc_in_zero_r
                              || (ref_tick.x16 && enc_bit_cnt == IPC_BIT_LAST));
        enc_pulse_nxt   = enc_pulse_r;
        if (enc_start) begin
            enc_pulse_nxt = 1'b1;
        end else if (enc_pulse_r && enc_sel_tick && enc_wid_cnt == enc_width_last) begin
            enc_pulse_nxt = 1'b0;
        end
        // Disabled path is a plain copy, one register stage late
        if (cfg.enable) begin
            tx_pin_nxt = !enc_pulse_nxt;
        end else begin
            tx_pin_nxt = serial_tx_in;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            enc_in_zero_r <= 1'b0;
            enc_pulse_r   <= 1'b0;
            tx_pin_r      <= IPC_LINE_IDLE;
        end else begin
            enc_in_zero_r <= enc_in_zero_nxt;
            enc_pulse_r   <= enc_pulse_nxt;
            tx_pin_r      <= tx_pin_nxt;
        end
    end

    // Bit-time counter, restarted with every pulse
    ipc_tick_counter #(.W(IPC_CNT_W)) u_enc_bit (
        .clock  (clock),
        .resetn (resetn),
        .clear  (enc_start),
        .tick   (ref_tick.x16),
        .hold   (1'b0),
        .count  (enc_bit_cnt)
    );

    // Pulse-width counter in the selected base clock
    ipc_tick_counter #(.W(IPC_CNT_W)) u_enc_wid (
        .clock  (clock),
        .resetn (resetn),
        .clear  (enc_start),
        .tick   (enc_sel_tick),
        .hold   (!enc_pulse_r),
        .count  (enc_wid_cnt)
    );

    // =====================================================================
    // Receive synchroniser
    // =====================================================================
    logic rx_meta_r;
    logic rx_sync_r;
    logic rx_prev_r;
    logic rx_fall;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rx_meta_r <= IPC_LINE_IDLE;
            rx_sync_r <= IPC_LINE_IDLE;
            rx_prev_r <= IPC_LINE_IDLE;
        end else begin
            rx_meta_r <= rx_pin;
            rx_sync_r <= rx_meta_r;
            rx_prev_r <= rx_sync_r;
        end
    end

    // A pulse is recognised by its leading edge only
    assign rx_fall = rx_prev_r && !rx_sync_r;

    // =====================================================================
    // Receive decoder
    // =====================================================================
    logic                 dec_run_r;
    logic                 dec_run_nxt;
    logic                 dec_jit_r;
    logic                 dec_jit_nxt;
    logic                 dec_out_r;
    logic                 dec_out_nxt;
    logic                 dec_clear;
    logic [IPC_CNT_W-1:0] dec_cnt;
    logic                 dec_serial_r;
    logic                 dec_serial_nxt;

    // A restart on a late pulse wins over reaching the end count, so a
    // pulse landing on the end tick restarts the bit instead of ending it.
    always_comb begin
        dec_run_nxt = dec_run_r;
        dec_jit_nxt = dec_jit_r;
        dec_out_nxt = dec_out_r;
        dec_clear   = 1'b0;
        if (!cfg.enable) begin
            dec_run_nxt = 1'b0;
            dec_jit_nxt = 1'b0;
            dec_out_nxt = IPC_LINE_IDLE;
        end else if (!dec_run_r) begin
            if (ref_tick.x16) begin
                dec_jit_nxt = 1'b0;
            end
            if (rx_fall && !dec_jit_r) begin
                dec_run_nxt = 1'b1;
                dec_clear   = 1'b1;
                dec_out_nxt = 1'b0;
            end
        end else if (rx_fall && dec_cnt > IPC_DEC_HOLD_LAST) begin
            dec_clear   = 1'b1;
            dec_out_nxt = 1'b0;
        end else if (ref_tick.x16 && dec_cnt == IPC_DEC_END - 4'h1) begin
            // Count is about to reach fifteen on this tick
            dec_run_nxt = 1'b0;
            dec_out_nxt = IPC_LINE_IDLE;
            dec_jit_nxt = 1'b1;
        end
        // Falls with count 0..7 take no branch above and are dropped
        if (cfg.enable) begin
            dec_serial_nxt = dec_out_nxt;
        end else begin
            dec_serial_nxt = rx_sync_r;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dec_run_r    <= 1'b0;
            dec_jit_r    <= 1'b0;
            dec_out_r    <= IPC_LINE_IDLE;
            dec_serial_r <= IPC_LINE_IDLE;
        end else begin
            dec_run_r    <= dec_run_nxt;
            dec_jit_r    <= dec_jit_nxt;
            dec_out_r    <= dec_out_nxt;
            dec_serial_r <= dec_serial_nxt;
        end
    end

    // Four-bit counter on the x16 reference only; frozen while stopped
    ipc_tick_counter #(.W(IPC_CNT_W)) u_dec_cnt (
        .clock  (clock),
        .resetn (resetn),
        .clear  (dec_clear),
        .tick   (ref_tick.x16),
        .hold   (!dec_run_r),
        .count  (dec_cnt)
    );

    // =====================================================================
    // Outputs
    // =====================================================================
    assign tx_pin            = tx_pin_r;
    assign decoded_serial_in = dec_serial_r;

endmodule

`default_nettype wire

// *** test/ipc_codec_chk.sv ***
// Port-level checks on the infrared pulse codec
`timescale 1ns/1ns
`default_nettype none

module ipc_codec_chk
    import ipc_pkg::*;
(
    input wire logic     clock,
    input wire logic     resetn,
    input wire ipc_cfg_t cfg,
    input wire logic     baud_x16_ref_clock,
    input wire logic     baud_x32_ref_clock,
    input wire logic     serial_tx_in,
    input wire logic     tx_pin,
    input wire logic     rx_pin,
    input wire logic     decoded_serial_in
);
    // ==========================================================
    // Count of x16 ticks while the decoded bit is low
    // ==========================================================
    logic [7:0] ticks_r;
    logic [7:0] ticks_nxt;
    always_comb begin
        ticks_nxt = ticks_r;
        if (decoded_serial_in) begin
            ticks_nxt = 8'h00;
        end else if (baud_x16_ref_clock && ticks_r != 8'hFF) begin
            ticks_nxt = ticks_r + 8'h01;
        end
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ticks_r <= 8'h00;
        end else begin
            ticks_r <= ticks_nxt;
        end
    end

    // ==========================================================
    // Assertions; widths assume x16 every 8 clocks, x32 every 4
    // ==========================================================
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_zero_start;
        serial_tx_in ##1 !serial_tx_in;
    endsequence
    sequence s_long_low;
        !tx_pin [*8] ##1 !tx_pin [*8];
    endsequence

    chk_pass_rx_follow: assert property (
        (!cfg.enable) [*4] |-> decoded_serial_in == $past(rx_pin, 3))
        else $error("rx pass-through differs");
    chk_pass_tx_follow: assert property (
        (!cfg.enable) [*2] |-> tx_pin == $past(serial_tx_in))
        else $error("tx pass-through differs");
    chk_tx_pulse_start: assert property (
        cfg.enable throughout s_zero_start |=> !tx_pin)
        else $error("no pulse for zero bit");
    chk_tx_width_316: assert property (
        $fell(tx_pin) && cfg.enable && cfg.width_sel == IPC_WIDTH_3_16
        |-> s_long_low ##[1:12] tx_pin) else $error("3/16 pulse width wrong");
    chk_tx_width_116: assert property (
        $fell(tx_pin) && cfg.enable && cfg.width_sel == IPC_WIDTH_1_16
        |-> !tx_pin ##[1:9] tx_pin) else $error("1/16 pulse width wrong");
    chk_tx_width_132: assert property (
        $fell(tx_pin) && cfg.enable && cfg.width_sel == IPC_WIDTH_1_32
        |-> !tx_pin ##[1:5] tx_pin) else $error("1/32 pulse width wrong");
    chk_tx_bit_spacing: assert property (
        $fell(tx_pin) && !$past(serial_tx_in, 2)
        |-> !$past(tx_pin, 128) && $past(tx_pin, 129))
        else $error("zero pulses not one bit apart");
    // The pin is first sampled low three edges before the decoded bit falls
    chk_rx_start_low: assert property (
        $fell(decoded_serial_in) && cfg.enable && $past(cfg.enable, 4)
        |-> $past(rx_pin, 4) && !$past(rx_pin, 3))
        else $error("decoded low without rx fall");
    chk_rx_full_count: assert property (
        $rose(decoded_serial_in) && cfg.enable |-> ticks_r >= 8'h0F)
        else $error("decoded bit ended early");
endmodule

bind ipc_codec ipc_codec_chk ipc_codec_chk_inst (
    .clock(clock), .resetn(resetn), .cfg(cfg),
    .baud_x16_ref_clock(baud_x16_ref_clock), .baud_x32_ref_clock(baud_x32_ref_clock),
    .serial_tx_in(serial_tx_in), .tx_pin(tx_pin), .rx_pin(rx_pin),
    .decoded_serial_in(decoded_serial_in));

`default_nettype wire

// *** test/ipc_ir_far.sv ***
// Far side: LED load on the transmit pin, photodiode on the receive pin
`timescale 1ns/1ns
`default_nettype none

module ipc_ir_far (
    input  wire logic clock,
    input  wire logic tx_pin,
    output logic      rx_pin
);
    int pulses = 0;
    int last_w = 0;
    int run = 0;
    initial rx_pin = 1'b1;
    // ==========================================================
    // Each LED flash is counted and its length kept in clocks
    // ==========================================================
    always @(posedge clock) begin
        if (tx_pin === 1'b0) begin
            run <= run + 1;
        end else if (run != 0) begin
            pulses <= pulses + 1;
            last_w <= run;
            run <= 0;
        end
    end
    // Diode output has a pull-up, so it idles high between flashes
    task automatic flash(input int n);
        rx_pin <= 1'b0;
        repeat (n) @(posedge clock);
        rx_pin <= 1'b1;
    endtask
endmodule

`default_nettype wire

// *** test/ipc_codec_tb.sv ***
// Self-checking bench for the infrared pulse codec
`timescale 1ns/1ns
`default_nettype none

module ipc_codec_tb
    import ipc_pkg::*;
;
    logic       clock = 1'b0;
    logic       resetn = 1'b0;
    ipc_cfg_t   cfg = '{enable: 1'b0, width_sel: IPC_WIDTH_3_16};
    logic       x16 = 1'b0;
    logic       x32 = 1'b0;
    logic       ser = 1'b1;
    logic       tx_pin;
    logic       rx_pin;
    logic       dec;
    logic [2:0] ph = 3'h0;
    int         fails = 0;
    int         checked = 0;

    ipc_codec ipc_codec_inst (.clock(clock), .resetn(resetn), .cfg(cfg),
        .baud_x16_ref_clock(x16), .baud_x32_ref_clock(x32), .serial_tx_in(ser),
        .tx_pin(tx_pin), .rx_pin(rx_pin), .decoded_serial_in(dec));
    ipc_ir_far ipc_ir_far_inst (.clock(clock), .tx_pin(tx_pin), .rx_pin(rx_pin));

    // ==========================================================
    // Clock and in-phase baud ticks: x16 every 8 clocks, x32 every 4
    // ==========================================================
    always #2 clock = ~clock;
    always @(posedge clock) begin
        ph <= ph + 3'h1;
        x16 <= (ph == 3'h7);
        x32 <= (ph[1:0] == 2'h3);
    end

    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    task automatic give_verdict;
        if (fails == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Bits change on the edge raising x16, as the core's shifter would
    task automatic tx_run(input logic en, input ipc_width_t w, input logic [2:0] v,
                          input int np, input int lo);
        int p0;
        @(posedge clock);
        cfg <= '{enable: en, width_sel: w};
        p0 = ipc_ir_far_inst.pulses;
        for (int i = 0; i < 4; i++) begin
            do @(posedge clock); while (ph != 3'h7);
            ser <= (i < 3) ? v[i] : 1'b1;
            repeat (120) @(posedge clock);
        end
        check("pulse count", 9'(ipc_ir_far_inst.pulses - p0), 9'(np));
        check("pulse width", 9'(ipc_ir_far_inst.last_w >= lo &&
              ipc_ir_far_inst.last_w <= lo + 1), 9'h001);
    endtask

    task automatic low_len(output int n);
        n = 0;
        for (int i = 0; i < 20 && dec !== 1'b0; i++) @(posedge clock);
        while (dec === 1'b0 && n < 400) begin
            n++;
            @(posedge clock);
        end
    endtask

    task automatic rx_run(input logic en, input int g, input int lo, input int hi);
        int n;
        @(posedge clock);
        cfg <= '{enable: en, width_sel: IPC_WIDTH_3_16};
        repeat (4) @(posedge clock);
        fork
            begin
                ipc_ir_far_inst.flash(3);
                if (g > 0) begin
                    repeat (g - 3) @(posedge clock);
                    ipc_ir_far_inst.flash(3);
                end
            end
            low_len(n);
        join
        check("decoded low time", 9'(n >= lo && n <= hi), 9'h001);
    endtask

    // A flash right after the bit ends falls before the next x16 tick
    task automatic rx_jitter;
        int   n;
        logic hi;
        hi = 1'b1;
        // The previous bit's jitter window must close before the first flash
        repeat (12) @(posedge clock);
        fork
            ipc_ir_far_inst.flash(3);
            low_len(n);
        join
        check("low before jitter", 9'(n >= 110 && n <= 124), 9'h001);
        ipc_ir_far_inst.flash(3);
        repeat (27) begin
            @(posedge clock);
            hi = hi & dec;
        end
        check("high after jitter", 9'(hi), 9'h001);
        fork
            ipc_ir_far_inst.flash(3);
            low_len(n);
        join
        check("low after window", 9'(n >= 110 && n <= 124), 9'h001);
    endtask

    initial begin
        repeat (12) @(posedge clock);
        check("tx idle", 9'(tx_pin), 9'h001);
        check("rx idle", 9'(dec), 9'h001);
        resetn <= 1'b1;
        tx_run(1'b1, IPC_WIDTH_3_16, 3'b000, 3, 24);
        tx_run(1'b1, IPC_WIDTH_1_16, 3'b110, 1, 8);
        tx_run(1'b1, IPC_WIDTH_1_32, 3'b110, 1, 4);
        tx_run(1'b1, ipc_width_t'(2'h3), 3'b110, 1, 24);
        tx_run(1'b0, IPC_WIDTH_3_16, 3'b010, 2, 128);
        rx_run(1'b0, 0, 3, 3);
        rx_run(1'b1, 0, 110, 124);
        rx_run(1'b1, 20, 110, 124);
        rx_run(1'b1, 80, 185, 210);
        rx_jitter;
        give_verdict;
    end

    initial begin
        #100000;
        fails++;
        give_verdict;
    end
endmodule

`default_nettype wire
